// *** timer2_map.svh ***
// Overview of operation
// R01: The count is one 16-bit value made of a high byte and a low byte.
// R02: The timer-or-counter select bit picks clock ticks or falling edges on the count input.
// R03: With run set, a serial clock select gives baud mode, else capture, reload or clock-out.
// R04: The auto-reload mode counts up, or down when down counting is enabled and the trigger is low.
// R05: The overflow flag is set by every overflow outside baud mode and only software clears it.
// R06: The overflow flag is not set while either serial clock select bit is 1.
// R07: A falling trigger edge that captures or reloads sets the external flag when enabled.
// R08: With the timer interrupt unmasked, a set external flag raises the interrupt.
// R09: Software clears the external flag; servicing the interrupt does not.
// R10: With down counting enabled, the external flag raises no interrupt.
// R11: In capture mode an enabled falling trigger edge copies the count into the capture pair; the code skips it while down counting is enabled.
// R12: An up-count overflow from 0xffff in reload mode loads the count from the reload pair.
// R13: A set serial clock select sends overflows to that serial clock, else the other timer's.
`ifndef TIMER2_MAP_SVH
`define TIMER2_MAP_SVH
`define CTRL_ADDR 8'h00
`define MODE_ADDR 8'h04
`define COUNT_LO_ADDR 8'h08
`define COUNT_HI_ADDR 8'h0c
`define CAP_LO_ADDR 8'h10
`define CAP_HI_ADDR 8'h14
`define IRQ_STATUS_ADDR 8'h18
`define IRQ_MASK_ADDR 8'h1c
`define CTRL_RESET 8'h00
`define BIT_OVF 7
`define BIT_EXT 6
`define BIT_RX_SEL 5
`define BIT_TX_SEL 4
`define BIT_EXT_EN 3
`define BIT_RUN 2
`define BIT_CNT_SEL 1
`define BIT_CAP_SEL 0
`define BIT_CLK_OE 1
`define BIT_DOWN_EN 0
`define COUNT_MAX 16'hffff
`endif

// *** timer2_pkg.sv ***
package timer2_pkg;
    typedef enum logic [2:0] {
        MODE_OFF, MODE_RELOAD, MODE_CAPTURE, MODE_BAUD, MODE_CLKOUT
    } timer_mode_t;
    typedef struct packed {
        logic [7:0] ctrl;
        logic [1:0] mode;
        logic [15:0] count;
        logic [15:0] cap;
        logic [1:0] irq_status;
        logic [1:0] irq_mask;
        logic [2:0] cnt_sync;
        logic [2:0] trg_sync;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic irq;
        logic rx_clk;
        logic tx_clk;
        logic clk_out;
    } timer_state_t;
endpackage

// *** timer2_capture_reload_core.sv ***
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "timer2_map.svh"
module timer2_capture_reload_core import timer2_pkg::*; (
    // APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Interrupt
    output logic irq,
    // Pins
    input wire logic count_pin,
    input wire logic trigger_pin,
    output logic clock_out_pin,
    // Serial port clocking
    input wire logic other_timer_overflow,
    output logic serial_rx_clock,
    output logic serial_tx_clock
);
    timer_state_t s;
    timer_state_t next_s;
    timer_mode_t mode;
    logic tick;
    logic trg_fall;
    logic down;
    logic ovf;
    logic ext_hit;
    logic acc;
    logic wr;

    // R03 mode decode
    always_comb begin
        if (!s.ctrl[`BIT_RUN]) begin
            mode = MODE_OFF;
        end else if (s.ctrl[`BIT_RX_SEL] || s.ctrl[`BIT_TX_SEL]) begin
            mode = MODE_BAUD;
        end else if (s.ctrl[`BIT_CAP_SEL]) begin
            mode = MODE_CAPTURE;
        end else if (s.mode[`BIT_CLK_OE]) begin
            mode = MODE_CLKOUT;
        end else begin
            mode = MODE_RELOAD;
        end
    end

    // R02 tick source: clock or falling count edge
    assign tick = s.ctrl[`BIT_CNT_SEL] ? (s.cnt_sync[2] & ~s.cnt_sync[1]) : 1'b1;
    assign trg_fall = s.trg_sync[2] & ~s.trg_sync[1];
    // R04 direction from trigger level
    assign down = (mode == MODE_RELOAD) && s.mode[`BIT_DOWN_EN] && !s.trg_sync[1];
    // R07 trigger acts only when enabled and in a mode that uses it
    assign ext_hit = trg_fall && s.ctrl[`BIT_EXT_EN] && !s.mode[`BIT_DOWN_EN]
        && (mode == MODE_CAPTURE || mode == MODE_RELOAD);
    assign acc = psel && penable && s.pready;
    assign wr = acc && pwrite;

    always_comb begin
        next_s = s;
        ovf = 1'b0;
        next_s.pready = 1'b0;
        next_s.pslverr = 1'b0;
        next_s.cnt_sync = {s.cnt_sync[1:0], count_pin};
        next_s.trg_sync = {s.trg_sync[1:0], trigger_pin};
        // R01 R12 counting
        if (mode != MODE_OFF && tick) begin
            if (down) begin
                if (s.count == s.cap) begin
                    next_s.count = `COUNT_MAX;
                    ovf = 1'b1;
                end else begin
                    next_s.count = s.count - 16'h0001;
                end
            end else if (s.count == `COUNT_MAX) begin
                ovf = 1'b1;
                next_s.count = (mode == MODE_CAPTURE) ? 16'h0000 : s.cap;
            end else begin
                next_s.count = s.count + 16'h0001;
            end
        end
        // R11 capture on trigger edge
        if (ext_hit && mode == MODE_CAPTURE) begin
            next_s.cap = s.count;
        end
        // Trigger reload overrides the count step
        if (ext_hit && mode == MODE_RELOAD) begin
            next_s.count = s.cap;
        end
        if (mode == MODE_CLKOUT && ovf) begin
            next_s.clk_out = ~s.clk_out;
        end
        // Register writes take effect at the access edge
        if (wr) begin
            case (paddr)
                `CTRL_ADDR: next_s.ctrl = pwdata[7:0];
                `MODE_ADDR: next_s.mode = pwdata[1:0];
                `COUNT_LO_ADDR: next_s.count[7:0] = pwdata[7:0];
                `COUNT_HI_ADDR: next_s.count[15:8] = pwdata[7:0];
                `CAP_LO_ADDR: next_s.cap[7:0] = pwdata[7:0];
                `CAP_HI_ADDR: next_s.cap[15:8] = pwdata[7:0];
                `IRQ_MASK_ADDR: next_s.irq_mask = pwdata[1:0];
                default: next_s.irq_mask = next_s.irq_mask;
            endcase
        end
        if (acc && !pwrite && paddr == `IRQ_STATUS_ADDR) begin
            next_s.irq_status = 2'b00;
        end
        // R05 R06 overflow flag, set wins over a software clear
        if (ovf && !s.ctrl[`BIT_RX_SEL] && !s.ctrl[`BIT_TX_SEL]) begin
            next_s.ctrl[`BIT_OVF] = 1'b1;
            next_s.irq_status[0] = 1'b1;
        end
        // R04 external flag toggles as a 17th bit when counting both ways
        if (ovf && mode == MODE_RELOAD && s.mode[`BIT_DOWN_EN]) begin
            next_s.ctrl[`BIT_EXT] = ~s.ctrl[`BIT_EXT];
        end
        // R07 R08 R10 external flag and its interrupt event
        if (ext_hit) begin
            next_s.ctrl[`BIT_EXT] = 1'b1;
            next_s.irq_status[1] = 1'b1;
        end
        next_s.irq = |(next_s.irq_status & next_s.irq_mask);
        // R13 serial clock routing
        next_s.rx_clk = s.ctrl[`BIT_RX_SEL] ? (ovf && mode == MODE_BAUD) : other_timer_overflow;
        next_s.tx_clk = s.ctrl[`BIT_TX_SEL] ? (ovf && mode == MODE_BAUD) : other_timer_overflow;
        // Answer one cycle after setup; outputs stay registered
        if (psel && !penable) begin
            next_s.pready = 1'b1;
            next_s.pslverr = (paddr[7:5] != 3'h0) || (paddr[1:0] != 2'h0);
            case (paddr)
                `CTRL_ADDR: next_s.prdata = {24'h000000, s.ctrl};
                `MODE_ADDR: next_s.prdata = {30'h00000000, s.mode};
                `COUNT_LO_ADDR: next_s.prdata = {24'h000000, s.count[7:0]};
                `COUNT_HI_ADDR: next_s.prdata = {24'h000000, s.count[15:8]};
                `CAP_LO_ADDR: next_s.prdata = {24'h000000, s.cap[7:0]};
                `CAP_HI_ADDR: next_s.prdata = {24'h000000, s.cap[15:8]};
                `IRQ_STATUS_ADDR: next_s.prdata = {30'h00000000, s.irq_status};
                `IRQ_MASK_ADDR: next_s.prdata = {30'h00000000, s.irq_mask};
                default: next_s.prdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign irq = s.irq;
    assign clock_out_pin = s.clk_out;
    assign serial_rx_clock = s.rx_clk;
    assign serial_tx_clock = s.tx_clk;

    // R12 up-count wrap reloads
    reload_wrap_a: assert property (@(posedge pclk) disable iff (!presetn) // R12
        (mode == MODE_RELOAD && !down && tick && s.count == 16'hffff && !ext_hit && !wr)
        |=> s.count == $past(s.cap))
        else $error("reload did not load the reload pair");
    // R01 single 16-bit count step
    count_step_a: assert property (@(posedge pclk) disable iff (!presetn) // R01
        (mode == MODE_CAPTURE && tick && s.count == 16'h00ff && !wr)
        |=> s.count == 16'h0100)
        else $error("low byte carry lost");
    // R03 run off holds the count
    run_off_a: assert property (@(posedge pclk) disable iff (!presetn) // R03
        (!s.ctrl[`BIT_RUN] && !wr) |=> s.count == $past(s.count))
        else $error("count moved while stopped");
    // R02 counter mode waits for edges
    counter_edge_a: assert property (@(posedge pclk) disable iff (!presetn) // R02
        (s.ctrl[`BIT_CNT_SEL] && !(s.cnt_sync[2] && !s.cnt_sync[1]) && !ext_hit && !wr)
        |=> s.count == $past(s.count))
        else $error("counter moved without an input edge");
    // R05 overflow flag set
    ovf_set_a: assert property (@(posedge pclk) disable iff (!presetn) // R05
        (ovf && mode != MODE_BAUD) |=> s.ctrl[`BIT_OVF] && s.irq_status[0])
        else $error("overflow flag not set");
    // R06 baud keeps flag clear
    baud_noflag_a: assert property (@(posedge pclk) disable iff (!presetn) // R06
        (mode == MODE_BAUD && !s.ctrl[`BIT_OVF] && !wr) |=> !s.ctrl[`BIT_OVF])
        else $error("overflow flag set in baud mode");
    // R07 external flag set
    ext_set_a: assert property (@(posedge pclk) disable iff (!presetn) // R07
        ext_hit |=> s.ctrl[`BIT_EXT] && s.irq_status[1])
        else $error("external flag not set");
    // R11 capture copies count
    capture_copy_a: assert property (@(posedge pclk) disable iff (!presetn) // R11
        (ext_hit && mode == MODE_CAPTURE && !wr) |=> s.cap == $past(s.count))
        else $error("capture pair not loaded");
    // R08 interrupt follows mask
    irq_raise_a: assert property (@(posedge pclk) disable iff (!presetn) // R08
        (ext_hit && s.irq_mask[1]) |=> irq)
        else $error("interrupt not raised");
    // R10 no event when counting both ways
    down_noirq_a: assert property (@(posedge pclk) disable iff (!presetn) // R10
        (s.mode[`BIT_DOWN_EN] && !s.irq_status[1] && !wr) |=> !s.irq_status[1])
        else $error("external event with down counting on");
    // R13 serial routing
    rx_route_a: assert property (@(posedge pclk) disable iff (!presetn) // R13
        (!s.ctrl[`BIT_RX_SEL]) |=> serial_rx_clock == $past(other_timer_overflow))
        else $error("receive clock not from other timer");
    // R01 capture wrap to zero
    count_wrap_a: assert property (@(posedge pclk) disable iff (!presetn) // R01
        (mode == MODE_CAPTURE && tick && s.count == 16'hffff && !wr) |=> s.count == 16'h0000)
        else $error("capture count did not wrap to zero");
    // R02 timer counts every clock
    timer_step_a: assert property (@(posedge pclk) disable iff (!presetn) // R02
        (mode == MODE_CAPTURE && !s.ctrl[`BIT_CNT_SEL] && s.count != 16'hffff && !wr) |=> s.count == $past(s.count) + 16'h0001)
        else $error("timer missed a clock");
    // R03 clock-out toggles
    clkout_toggle_a: assert property (@(posedge pclk) disable iff (!presetn) // R03
        (mode == MODE_CLKOUT && ovf) |=> clock_out_pin != $past(clock_out_pin))
        else $error("clock out did not toggle");
    // R03 clock-out idle elsewhere
    clkout_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // R03
        (mode != MODE_CLKOUT) |=> clock_out_pin == $past(clock_out_pin))
        else $error("clock out moved outside its mode");
    // R04 down count step
    down_step_a: assert property (@(posedge pclk) disable iff (!presetn) // R04
        (down && tick && s.count != s.cap && !wr) |=> s.count == $past(s.count) - 16'h0001)
        else $error("down count step wrong");
    // R04 underflow loads all ones
    down_wrap_a: assert property (@(posedge pclk) disable iff (!presetn) // R04
        (down && tick && s.count == s.cap && !wr) |=> s.count == 16'hffff)
        else $error("underflow did not load all ones");
    // R04 external flag toggles
    ext_toggle_a: assert property (@(posedge pclk) disable iff (!presetn) // R04
        (down && tick && s.count == s.cap && !wr) |=> s.ctrl[`BIT_EXT] != $past(s.ctrl[`BIT_EXT]))
        else $error("external flag did not toggle on underflow");
    // R05 overflow flag sticky
    ovf_sticky_a: assert property (@(posedge pclk) disable iff (!presetn) // R05
        (s.ctrl[`BIT_OVF] && !wr) |=> s.ctrl[`BIT_OVF])
        else $error("overflow flag cleared by hardware");
    // R05 status bit sticky
    status_sticky_a: assert property (@(posedge pclk) disable iff (!presetn) // R05
        (s.irq_status[0] && !(acc && !pwrite && paddr == `IRQ_STATUS_ADDR)) |=> s.irq_status[0])
        else $error("overflow status lost without a read");
    // R06 baud raises no status
    baud_nostatus_a: assert property (@(posedge pclk) disable iff (!presetn) // R06
        (mode == MODE_BAUD && !s.irq_status[0]) |=> !s.irq_status[0])
        else $error("overflow status set in baud mode");
    // R07 trigger needs enable
    ext_enable_a: assert property (@(posedge pclk) disable iff (!presetn) // R07
        (!s.ctrl[`BIT_EXT_EN] && !s.ctrl[`BIT_EXT] && !wr && !s.mode[`BIT_DOWN_EN]) |=> !s.ctrl[`BIT_EXT])
        else $error("external flag set while trigger disabled");
    // R07 external flag sticky
    ext_sticky_a: assert property (@(posedge pclk) disable iff (!presetn) // R07
        (s.ctrl[`BIT_EXT] && !wr && !s.mode[`BIT_DOWN_EN]) |=> s.ctrl[`BIT_EXT])
        else $error("external flag cleared by hardware");
    // R07 trigger reloads count
    trig_reload_a: assert property (@(posedge pclk) disable iff (!presetn) // R07
        (ext_hit && mode == MODE_RELOAD && !wr) |=> s.count == $past(s.cap))
        else $error("trigger did not reload the count");
    // R08 interrupt level
    irq_level_a: assert property (@(posedge pclk) disable iff (!presetn) // R08
        irq == |(s.irq_status & s.irq_mask))
        else $error("interrupt level does not match status and mask");
    // R11 capture pair holds
    capture_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // R11
        (mode == MODE_CAPTURE && !ext_hit && !wr) |=> s.cap == $past(s.cap))
        else $error("capture pair changed without a trigger");
    // R13 transmit routing
    tx_route_a: assert property (@(posedge pclk) disable iff (!presetn) // R13
        (!s.ctrl[`BIT_TX_SEL]) |=> serial_tx_clock == $past(other_timer_overflow))
        else $error("transmit clock not from other timer");
    // R13 baud pulse to receive
    rx_baud_a: assert property (@(posedge pclk) disable iff (!presetn) // R13
        (s.ctrl[`BIT_RX_SEL] && ovf && mode == MODE_BAUD) |=> serial_rx_clock)
        else $error("receive clock missed an overflow");
    // R13 receive quiet between
    rx_quiet_a: assert property (@(posedge pclk) disable iff (!presetn) // R13
        (s.ctrl[`BIT_RX_SEL] && !ovf) |=> !serial_rx_clock)
        else $error("receive clock pulsed without overflow");
    // Bus answers after setup
    setup_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable) |=> pready)
        else $error("no answer after setup");
    // Bus error on unmapped space
    bus_error_a: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && paddr[7:5] != 3'h0) |=> pslverr)
        else $error("unmapped access without error");

    capture_c: cover property (@(posedge pclk) disable iff (!presetn)
        ext_hit && mode == MODE_CAPTURE);
    down_wrap_c: cover property (@(posedge pclk) disable iff (!presetn) ovf && down);
    baud_c: cover property (@(posedge pclk) disable iff (!presetn) serial_tx_clock && s.ctrl[`BIT_TX_SEL]);
    clkout_c: cover property (@(posedge pclk) disable iff (!presetn) clock_out_pin);
    trig_reload_c: cover property (@(posedge pclk) disable iff (!presetn)
        ext_hit && mode == MODE_RELOAD);
endmodule
`default_nettype wire

// *** timer2_pins.sv ***
`timescale 1ns/10ps
`default_nettype none
module timer2_pins (
    // Clock
    input wire logic pclk,
    // Pins
    output logic count_pin,
    output logic trigger_pin,
    output logic other_timer_overflow
);
    int div = 0;
    initial begin
        count_pin = 1'b1;
        trigger_pin = 1'b1;
        other_timer_overflow = 1'b0;
    end
    // Other timer overflows every seven clocks
    always @(posedge pclk) begin
        div <= (div == 6) ? 0 : div + 1;
        other_timer_overflow <= (div == 6);
    end
    // Each level held two clocks so the synchroniser sees it
    task automatic pulse(input bit trg, input int n);
        repeat (n) begin
            @(posedge pclk);
            if (trg) trigger_pin <= 1'b0; else count_pin <= 1'b0;
            repeat (2) @(posedge pclk);
            if (trg) trigger_pin <= 1'b1; else count_pin <= 1'b1;
            @(posedge pclk);
        end
    endtask
    task automatic level(input logic v);
        @(posedge pclk);
        trigger_pin <= v;
    endtask
endmodule
`default_nettype wire

// *** test_timer2_capture_reload_core.sv ***
`timescale 1ns/10ps
`default_nettype none
module test_timer2_capture_reload_core;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, clock_out_pin;
    logic count_pin, trigger_pin, other_timer_overflow, serial_rx_clock, serial_tx_clock;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r, r2;
    logic err;
    int n_errors = 0, checked = 0, cyc = 0, n_tx, n_rx, n_irq;
    logic [15:0] v;
    timer2_capture_reload_core u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq), .count_pin(count_pin),
        .trigger_pin(trigger_pin), .clock_out_pin(clock_out_pin),
        .other_timer_overflow(other_timer_overflow), .serial_rx_clock(serial_rx_clock),
        .serial_tx_clock(serial_tx_clock));
    timer2_pins u_pins (.pclk(pclk), .count_pin(count_pin), .trigger_pin(trigger_pin),
        .other_timer_overflow(other_timer_overflow));
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        n_tx += (serial_tx_clock === 1'b1);
        n_rx += (serial_rx_clock === 1'b1);
        n_irq += (irq === 1'b1);
        if (cyc == 20000) begin
            n_errors++;
            test_done();
        end
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // pready ends this wait; only the bench timeout ends it if pready never rises
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic load(input logic [15:0] c, input logic [15:0] p);
        apb(1, 8'h08, {24'h0, c[7:0]});
        apb(1, 8'h0c, {24'h0, c[15:8]});
        apb(1, 8'h10, {24'h0, p[7:0]});
        apb(1, 8'h14, {24'h0, p[15:8]});
    endtask
    initial begin
        {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
        void'($urandom(32'hac28));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            apb(0, 8'(i * 4), 0);
            chk("reset value", r, 0);
        end
        apb(0, 8'h20, 0);
        chk("unmapped error", {31'h0, err}, 1);
        $display("test reset done");
        load(16'hfffe, 16'h1234);
        apb(1, 8'h00, 32'h04);
        repeat (8) @(posedge pclk);
        apb(0, 8'h00, 0);
        chk("reload flag", r, 32'h84);
        apb(0, 8'h0c, 0);
        chk("reload high", r, 32'h12);
        apb(0, 8'h18, 0);
        chk("status ovf", r, 32'h1);
        for (int i = 0; i < 2; i++) begin
            apb(1, 8'h00, 32'h0);
            load(16'hfffe, 16'h1234);
            apb(1, 8'h00, i ? 32'h14 : 32'h24);
            // Skip pulses still routed from the other timer
            repeat (2) @(posedge pclk);
            {n_tx, n_rx} = '0;
            repeat (8) @(posedge pclk);
            apb(0, 8'h00, 0);
            chk("baud flag clear", r, i ? 32'h14 : 32'h24);
            chk("serial clock", i ? n_tx : n_rx, 1);
        end
        $display("test reload and baud done");
        apb(1, 8'h00, 0);
        apb(1, 8'h04, 32'h2);
        load(16'hfffe, 16'h1234);
        apb(1, 8'h00, 32'h04);
        repeat (8) @(posedge pclk);
        chk("clock out", clock_out_pin, 1);
        apb(1, 8'h00, 0);
        apb(1, 8'h04, 0);
        apb(0, 8'h18, 0);
        v = 16'($urandom) & 16'h7fff;
        load(v, 0);
        apb(1, 8'h1c, 32'h2);
        apb(1, 8'h00, 32'h0f);
        u_pins.pulse(1, 1);
        repeat (6) @(posedge pclk);
        apb(0, 8'h10, 0);
        r2 = r;
        apb(0, 8'h14, 0);
        chk("capture", {r[7:0], r2[7:0]}, v);
        apb(0, 8'h00, 0);
        chk("ext flag", r, 32'h4f);
        chk("irq", irq, 1);
        apb(0, 8'h18, 0);
        repeat (2) @(posedge pclk);
        chk("irq clear", irq, 0);
        apb(1, 8'h00, 32'h0f);
        apb(0, 8'h00, 0);
        chk("ext clear", r, 32'h0f);
        u_pins.pulse(0, 3);
        repeat (6) @(posedge pclk);
        apb(0, 8'h08, 0);
        r2 = r;
        apb(0, 8'h0c, 0);
        chk("event count", {r[7:0], r2[7:0]}, v + 3);
        $display("test capture done");
        apb(1, 8'h00, 0);
        apb(0, 8'h18, 0);
        apb(1, 8'h04, 32'h1);
        load(16'h0005, 0);
        u_pins.level(0);
        n_irq = 0;
        apb(1, 8'h00, 32'h0c);
        repeat (20) @(posedge pclk);
        apb(0, 8'h00, 0);
        chk("down flags", r, 32'hcc);
        chk("down irq", n_irq, 0);
        apb(1, 8'h00, 0);
        apb(0, 8'h08, 0);
        r2 = r;
        repeat (5) @(posedge pclk);
        apb(0, 8'h08, 0);
        chk("stopped", r, r2);
        $display("test down and off done");
        apb(0, 8'h18, 0);
        load(16'h0100, 16'h4321);
        u_pins.level(1);
        apb(1, 8'h04, 32'h0);
        apb(1, 8'h00, 32'h0c);
        u_pins.pulse(1, 1);
        repeat (6) @(posedge pclk);
        apb(0, 8'h0c, 0);
        chk("trigger reload", r, 32'h43);
        apb(0, 8'h00, 0);
        chk("reload ext flag", r, 32'h4c);
        $display("test trigger reload done");
        test_done();
    end
endmodule
`default_nettype wire
